// File: csel_clock_select.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module csel_clock_select
  import csel_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CNT = csel_pkg::PLL_LOCK_CYCLES,
  parameter int unsigned EXT_STOP_CNT = csel_pkg::EXT_STOP_CYCLES
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst_n,
  input  wire csel_pkg::csel_cfg_type      i_cfg,
  input  wire logic [csel_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [csel_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire csel_pkg::csel_osc_type      i_osc,
  input  wire logic                        i_sys_clk_lvl,
  input  wire logic                        i_clock_input_pin_lvl,
  output logic [csel_pkg::DATA_W-1:0]      o_rdata,
  output csel_pkg::csel_sel_type           o_sel,
  output logic                             o_hf_osc_en,
  output logic                             o_lf_osc_en,
  output logic                             o_pll_en,
  output logic                             o_cpu_run,
  output logic                             o_clock_input_pin_gpio,
  output logic                             o_clock_output_pin_en,
  output logic                             o_switch_busy
);
  import csel_pkg::*;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_STARTUP = 2'b01,
    ST_WAITF   = 2'b11,
    ST_COMMIT  = 2'b10
  } csel_state_type;
  localparam logic [TIMER_W-1:0] HF_LOAD  = TIMER_W'(HF_STARTUP_CYCLES);
  localparam logic [TIMER_W-1:0] LF_LOAD  = TIMER_W'(LF_STARTUP_CYCLES);
  localparam logic [TIMER_W-1:0] PLL_LOAD = TIMER_W'(PLL_LOCK_CNT);
  localparam logic [7:0]         EXT_MAX  = 8'(EXT_STOP_CNT);
  // synchronised pin levels
  csel_osc_type osc_s;
  logic         sys_clk_s;
  logic         clock_input_pin_s;
  logic [5:0]   async_in;
  logic [5:0]   sync_out;
  assign async_in = {i_osc, i_sys_clk_lvl, i_clock_input_pin_lvl};
  assign osc_s    = csel_osc_type'(sync_out[5:2]);
  assign sys_clk_s = sync_out[1];
  assign clock_input_pin_s   = sync_out[0];
  csel_sync #(.W(6)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (async_in),
    .o_sync    (sync_out)
  );

  // configuration captured while reset is held
  csel_cfg_type cfg_r;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      cfg_r <= i_cfg;
  end

  // control register
  logic       pll_soft_enable_r;
  logic       pll_soft_enable_nxt;
  logic [3:0] internal_freq_select_r;
  logic [3:0] internal_freq_select_nxt;
  logic [1:0] runtime_source_select_r;
  logic [1:0] runtime_source_select_nxt;
  always_comb
  begin
    pll_soft_enable_nxt       = pll_soft_enable_r;
    internal_freq_select_nxt  = internal_freq_select_r;
    runtime_source_select_nxt = runtime_source_select_r;
    if (i_wr && i_addr == OFF_CONTROL)
    begin
      pll_soft_enable_nxt       = i_wdata[CTL_PLL_BIT];
      internal_freq_select_nxt  = i_wdata[CTL_FREQ_LSB +: 4];
      runtime_source_select_nxt = i_wdata[CTL_RSEL_LSB +: 2];
    end
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      pll_soft_enable_r       <= PLL_RESET;
      internal_freq_select_r  <= FREQ_RESET;
      runtime_source_select_r <= RSEL_RESET;
    end
    else
    begin
      pll_soft_enable_r       <= pll_soft_enable_nxt;
      internal_freq_select_r  <= internal_freq_select_nxt;
      runtime_source_select_r <= runtime_source_select_nxt;
    end
  end

  // requested selection, decoded from configuration and control
  logic         int_sel;
  logic         pll_ok;
  csel_sel_type tgt;
  // reserved run-time code 01 behaves like 00, except that only 00 lets the pll be chosen
  assign int_sel = runtime_source_select_r[1] ||
                   (cfg_r.cfg_clock_source == CFG_INTERNAL);
  assign pll_ok  = (cfg_r.cfg_clock_source == CFG_INTERNAL) &&
                   (runtime_source_select_r == RSEL_RESET) &&
                   (internal_freq_select_r == FREQ_PLL_BASE) &&
                   pll_soft_enable_r;
  always_comb
  begin
    tgt = '{src: SRC_HF, div_log2: freq_div_log2(internal_freq_select_r)};
    if (!int_sel)
      tgt = '{src: SRC_EXT, div_log2: DIV_NONE};
    else if (internal_freq_select_r[3:1] == 3'h0)
      tgt = '{src: SRC_LF, div_log2: DIV_NONE};
    else if (pll_ok)
      tgt = '{src: SRC_PLL, div_log2: DIV_PLL_BASE};
  end

  // live oscillator readiness
  logic pll_time_done;
  logic pll_ready;
  csel_delay #(.W(TIMER_W)) u_pll_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_load    (!o_pll_en),
    .i_count   (PLL_LOAD),
    .o_done    (pll_time_done)
  );
  assign pll_ready = osc_s.pll_locked && pll_time_done && o_pll_en;
  function automatic logic src_ready(input csel_src_type s, input csel_osc_type o,
                                     input logic pll_rdy);
    logic r;
    r = 1'b1;
    unique case (s)
      SRC_EXT: r = 1'b1;
      SRC_HF:  r = o.hf_running;
      SRC_LF:  r = o.lf_running;
      SRC_PLL: r = pll_rdy;
    endcase
    return r;
  endfunction : src_ready
  function automatic logic needs_hf(input csel_src_type s);
    return (s == SRC_HF) || (s == SRC_PLL);
  endfunction : needs_hf

  // switch sequencer
  csel_state_type state_r;
  csel_state_type state_nxt;
  csel_sel_type   cur_r;
  csel_sel_type   cur_nxt;
  csel_sel_type   pend_r;
  csel_sel_type   pend_nxt;
  logic           sys_prev_r;
  logic           sys_fall;
  logic           tmr_load;
  logic [TIMER_W-1:0] tmr_count;
  logic           tmr_done;
  assign sys_fall = sys_prev_r && !sys_clk_s;
  always_comb
  begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    pend_nxt  = pend_r;
    tmr_load  = 1'b0;
    tmr_count = HF_LOAD;
    unique case (state_r)
      ST_IDLE:
      begin
        if (tgt != cur_r)
        begin
          pend_nxt = tgt;
          // an already running oscillator needs no start-up
          if (src_ready(tgt.src, osc_s, pll_ready))
            state_nxt = ST_WAITF;
          else
          begin
            tmr_load  = 1'b1;
            tmr_count = (tgt.src == SRC_LF) ? LF_LOAD : HF_LOAD;
            state_nxt = ST_STARTUP;
          end
        end
      end
      ST_STARTUP:
      begin
        if (tmr_done && src_ready(pend_r.src, osc_s, pll_ready))
          state_nxt = ST_WAITF;
      end
      ST_WAITF:
      begin
        // switch only while the old clock is low, so no runt phase
        if (sys_fall)
          state_nxt = ST_COMMIT;
      end
      ST_COMMIT:
      begin
        cur_nxt   = pend_r;
        state_nxt = ST_IDLE;
      end
    endcase
  end
  csel_delay #(.W(TIMER_W)) u_start_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_done    (tmr_done)
  );
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state_r    <= ST_IDLE;
      // reset lands straight on the configured source
      cur_r      <= (i_cfg.cfg_clock_source == CFG_INTERNAL) ?
                    '{src: SRC_HF, div_log2: freq_div_log2(FREQ_RESET)} :
                    '{src: SRC_EXT, div_log2: DIV_NONE};
      pend_r     <= '{src: SRC_EXT, div_log2: DIV_NONE};
      sys_prev_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      cur_r      <= cur_nxt;
      pend_r     <= pend_nxt;
      sys_prev_r <= sys_clk_s;
    end
  end

  // external clock stop detection
  logic [7:0] ext_idle_r;
  logic [7:0] ext_idle_nxt;
  logic       clock_input_pin_prev_r;
  logic       ext_stopped;
  assign ext_stopped = (ext_idle_r == EXT_MAX);
  always_comb
  begin
    ext_idle_nxt = ext_idle_r;
    if (clock_input_pin_s != clock_input_pin_prev_r)
      ext_idle_nxt = 8'h0;
    else if (!ext_stopped)
      ext_idle_nxt = ext_idle_r + 8'h1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      ext_idle_r   <= 8'h0;
      clock_input_pin_prev_r <= 1'b0;
    end
    else
    begin
      ext_idle_r   <= ext_idle_nxt;
      clock_input_pin_prev_r <= clock_input_pin_s;
    end
  end

  // oscillator enables and pin functions
  logic busy;
  logic hf_en_nxt;
  logic lf_en_nxt;
  logic pll_en_nxt;
  logic run_nxt;
  assign busy = (state_r != ST_IDLE);
  always_comb
  begin
    // keep the old source alive until the switch completes
    hf_en_nxt  = (int_sel && needs_hf(tgt.src)) || needs_hf(cur_r.src) ||
                 (busy && needs_hf(pend_r.src));
    lf_en_nxt  = (int_sel && tgt.src == SRC_LF) || cur_r.src == SRC_LF ||
                 (busy && pend_r.src == SRC_LF) ||
                 !cfg_r.power_up_timer_enable_n || (cfg_r.wdt_enable != 2'h0);
    pll_en_nxt = (tgt.src == SRC_PLL) || (cur_r.src == SRC_PLL) ||
                 (busy && pend_r.src == SRC_PLL);
    if (cur_r.src == SRC_EXT)
      run_nxt = !ext_stopped;
    else
      run_nxt = src_ready(cur_r.src, osc_s, pll_ready);
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_hf_osc_en   <= 1'b0;
      o_lf_osc_en   <= 1'b0;
      o_pll_en      <= 1'b0;
      o_cpu_run     <= 1'b0;
      o_clock_input_pin_gpio  <= 1'b0;
      o_clock_output_pin_en   <= 1'b0;
      o_switch_busy <= 1'b0;
      o_sel         <= '{src: SRC_EXT, div_log2: DIV_NONE};
    end
    else
    begin
      o_hf_osc_en   <= hf_en_nxt;
      o_lf_osc_en   <= lf_en_nxt;
      o_pll_en      <= pll_en_nxt;
      o_cpu_run     <= run_nxt;
      o_clock_input_pin_gpio  <= (cfg_r.cfg_clock_source == CFG_INTERNAL);
      o_clock_output_pin_en   <= !cfg_r.clock_out_enable_n;
      o_switch_busy <= busy;
      o_sel         <= cur_r;
    end
  end

  // register read port
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] status_word;
  always_comb
  begin
    status_word               = '0;
    status_word[ST_PLL_READY] = pll_ready;
    status_word[ST_HF_READY]  = osc_s.hf_running && o_hf_osc_en;
    status_word[ST_LF_READY]  = osc_s.lf_running && o_lf_osc_en;
    status_word[ST_HF_STABLE] = osc_s.hf_in_band && o_hf_osc_en;
    rdata_nxt = '0;
    if (i_rd)
    begin
      unique case (i_addr)
        OFF_CONTROL: rdata_nxt = {pll_soft_enable_r, internal_freq_select_r, 1'b0,
                                  runtime_source_select_r};
        OFF_STATUS:  rdata_nxt = status_word;
        OFF_ACTIVE:  rdata_nxt = {busy, !o_cpu_run, cur_r.src, cur_r.div_log2};
        default:     rdata_nxt = '0;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_rdata <= '0;
    else
      o_rdata <= rdata_nxt;
  end
endmodule : csel_clock_select

// File: csel_pkg.sv
package csel_pkg;

  localparam int unsigned REF_CLK_HZ        = 20_000_000;
  localparam int unsigned REF_CLK_PERIOD_NS = 50;

  // start-up delays of the internal oscillators and the pll, the external stop limit and the timer width
  localparam int unsigned HF_STARTUP_NS     = 2000;
  localparam int unsigned HF_STARTUP_CYCLES =
    (HF_STARTUP_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int unsigned LF_OSC_HZ         = 31_000;
  localparam int unsigned LF_STARTUP_CYCLES = (REF_CLK_HZ + LF_OSC_HZ - 1) / LF_OSC_HZ;
  localparam int unsigned PLL_LOCK_US       = 2000;
  localparam int unsigned PLL_LOCK_CYCLES   = PLL_LOCK_US * (REF_CLK_HZ / 1_000_000);
  localparam int unsigned EXT_STOP_CYCLES   = 64;
  localparam int unsigned TIMER_W           = 16;

  // register map
  localparam int unsigned ADDR_W     = 2;
  localparam int unsigned DATA_W     = 8;
  localparam logic [1:0]  OFF_CONTROL = 2'h0;
  localparam logic [1:0]  OFF_STATUS  = 2'h1;
  localparam logic [1:0]  OFF_ACTIVE  = 2'h2;

  // control register fields
  localparam int unsigned CTL_PLL_BIT  = 7;
  localparam int unsigned CTL_FREQ_LSB = 3;
  localparam int unsigned CTL_RSEL_LSB = 0;
  localparam logic [3:0]  FREQ_RESET   = 4'h7;
  localparam logic [1:0]  RSEL_RESET   = 2'h0;
  localparam logic        PLL_RESET    = 1'h0;
  localparam logic [3:0]  FREQ_PLL_BASE = 4'he;

  // status register fields
  localparam int unsigned ST_PLL_READY = 6;
  localparam int unsigned ST_HF_READY  = 4;
  localparam int unsigned ST_LF_READY  = 1;
  localparam int unsigned ST_HF_STABLE = 0;

  // configuration source codes
  localparam logic [1:0] CFG_INTERNAL  = 2'h0;
  localparam logic [1:0] CFG_EXT_LOW   = 2'h1;
  localparam logic [1:0] CFG_EXT_MED   = 2'h2;
  localparam logic [1:0] CFG_EXT_HIGH  = 2'h3;

  localparam logic [3:0] DIV_PLL_BASE  = 4'h1;
  localparam logic [3:0] DIV_NONE      = 4'h0;

  typedef enum logic [1:0] {
    SRC_EXT = 2'h0,
    SRC_HF  = 2'h1,
    SRC_LF  = 2'h2,
    SRC_PLL = 2'h3
  } csel_src_type;

  typedef struct packed {
    csel_src_type src;
    logic [3:0]   div_log2;
  } csel_sel_type;

  typedef struct packed {
    logic       clock_out_enable_n;
    logic       power_up_timer_enable_n;
    logic [1:0] wdt_enable;
    logic [1:0] cfg_clock_source;
  } csel_cfg_type;

  typedef struct packed {
    logic pll_locked;
    logic hf_running;
    logic hf_in_band;
    logic lf_running;
  } csel_osc_type;

  // log2 of the postscaler ratio off the 16 MHz oscillator
  function automatic logic [3:0] freq_div_log2(input logic [3:0] code);
    logic [3:0] d;
    d = DIV_NONE;
    if (code[3])
      d = 4'hf - code;
    else if (code[2])
      d = 4'hc - code;
    else if (code[1])
      d = 4'h9;
    return d;
  endfunction : freq_div_log2

endpackage : csel_pkg

// File: csel_sync.sv
`timescale 1ns/1ps
module csel_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule : csel_sync

// File: csel_delay.sv
`timescale 1ns/1ps
module csel_delay #(
  parameter int unsigned W = 16
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_load)
      cnt_nxt = i_count;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - W'(1);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign o_done = (cnt_r == '0) && !i_load;

endmodule : csel_delay

// File: csel_ext_osc_model.sv
`timescale 1ns/1ps
// external clock oscillator on the clock input pin; holds its level while stopped
module csel_ext_osc_model #(
  parameter int unsigned HALF = 2
) (
  input  wire logic i_ref_clk,
  input  wire logic i_run,
  output logic      o_clk_lvl
);
  int unsigned cnt = 0;

  initial o_clk_lvl = 1'b0;

  // a stopped oscillator freezes mid-phase, like a gated crystal module
  always @(posedge i_ref_clk)
  begin
    if (i_run)
    begin
      cnt <= (cnt + 1) % HALF;
      if (cnt == HALF - 1)
        o_clk_lvl <= ~o_clk_lvl;
    end
  end
endmodule : csel_ext_osc_model

// File: csel_clock_select_monitor.sv
`timescale 1ns/1ps
module csel_clock_select_monitor
  import csel_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CNT = 20,
  parameter int unsigned EXT_STOP_CNT = 8
) (
  input wire logic                        i_ref_clk,
  input wire logic                        i_rst_n,
  input wire csel_pkg::csel_cfg_type      i_cfg,
  input wire logic [csel_pkg::ADDR_W-1:0] i_addr,
  input wire logic [csel_pkg::DATA_W-1:0] i_wdata,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire csel_pkg::csel_osc_type      i_osc,
  input wire logic                        i_sys_clk_lvl,
  input wire logic                        i_clock_input_pin_lvl,
  input wire logic [csel_pkg::DATA_W-1:0] o_rdata,
  input wire csel_pkg::csel_sel_type      o_sel,
  input wire logic                        o_hf_osc_en,
  input wire logic                        o_lf_osc_en,
  input wire logic                        o_pll_en,
  input wire logic                        o_cpu_run,
  input wire logic                        o_clock_input_pin_gpio,
  input wire logic                        o_clock_output_pin_en,
  input wire logic                        o_switch_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_gpio_pin_cfg: assert property ($past(i_rst_n) |->
    o_clock_input_pin_gpio == (i_cfg.cfg_clock_source == CFG_INTERNAL))
    else $error("input pin role does not follow configuration");
  a_clock_output_pin_pin_cfg: assert property ($past(i_rst_n) |->
    o_clock_output_pin_en == !i_cfg.clock_out_enable_n)
    else $error("clock output role does not follow configuration");
  a_ext_only_cfg: assert property ($past(i_rst_n) && o_sel.src == SRC_EXT |->
    i_cfg.cfg_clock_source != CFG_INTERNAL && o_sel.div_log2 == DIV_NONE)
    else $error("external source active without external configuration");
  a_pll_only_cfg: assert property (o_sel.src == SRC_PLL |->
    i_cfg.cfg_clock_source == CFG_INTERNAL && o_sel.div_log2 == DIV_PLL_BASE && o_pll_en)
    else $error("pll selected in a forbidden setting");
  a_lf_sel_en: assert property (o_sel.src == SRC_LF |->
    o_sel.div_log2 == DIV_NONE && o_lf_osc_en)
    else $error("low oscillator selected but not enabled");
  a_hf_sel_en: assert property ($past(i_rst_n) && o_sel.src == SRC_HF |->
    o_hf_osc_en)
    else $error("high oscillator selected but not enabled");
  a_lf_timers_on: assert property ($past(i_rst_n) &&
    (!i_cfg.power_up_timer_enable_n || i_cfg.wdt_enable != 2'h0) |-> o_lf_osc_en)
    else $error("low oscillator off while timers need it");
  // a mux change outside a switch sequence would risk a runt phase
  // the reset value of the selection is left one edge after release, so skip that edge
  a_sel_in_switch: assert property ($past(i_rst_n, 2) && $changed(o_sel) |->
    o_switch_busy || $past(o_switch_busy))
    else $error("selection changed outside a switch sequence");
  a_rdata_idle: assert property ($past(i_rst_n) && !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  a_status_unused: assert property ($past(i_rd) && $past(i_addr) == OFF_STATUS |->
    (o_rdata & 8'hac) == 8'h00)
    else $error("unused status bits read nonzero");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) == 2'h3 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  c_busy: cover property ($rose(o_switch_busy));
  c_pll: cover property (o_sel.src == SRC_PLL);
  c_lf: cover property (o_sel.src == SRC_LF);
  c_halt: cover property ($fell(o_cpu_run));
endmodule : csel_clock_select_monitor

bind csel_clock_select csel_clock_select_monitor #(
  .PLL_LOCK_CNT(PLL_LOCK_CNT),
  .EXT_STOP_CNT(EXT_STOP_CNT)
) u_mon (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_osc(i_osc),
  .i_sys_clk_lvl(i_sys_clk_lvl), .i_clock_input_pin_lvl(i_clock_input_pin_lvl), .o_rdata(o_rdata),
  .o_sel(o_sel), .o_hf_osc_en(o_hf_osc_en), .o_lf_osc_en(o_lf_osc_en),
  .o_pll_en(o_pll_en), .o_cpu_run(o_cpu_run), .o_clock_input_pin_gpio(o_clock_input_pin_gpio),
  .o_clock_output_pin_en(o_clock_output_pin_en), .o_switch_busy(o_switch_busy)
);

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import csel_pkg::*;
  logic         clk       = 1'b0;
  logic         rst_n     = 1'b0;
  csel_cfg_type cfg       = 6'h13;
  logic [1:0]   addr      = 2'h0;
  logic [7:0]   wdata     = 8'h00;
  logic         wr        = 1'b0;
  logic         rd        = 1'b0;
  csel_osc_type osc       = 4'h0;
  logic         sys_lvl   = 1'b0;
  logic         ext_run   = 1'b1;
  logic         clock_input_pin_lvl;
  logic [7:0]   rdata;
  csel_sel_type sel;
  logic         hf_en, lf_en, pll_en, cpu_run, gpio, clock_output_pin_en, busy;
  int           num_errors  = 0;
  int           comparisons = 0;
  int           cyc         = 0;

  always #25 clk = ~clk;

  // analog oscillators answer their enables a cycle late; the hf in-band flag follows hf running a cycle later still
  always @(posedge clk)
  begin
    sys_lvl <= ~sys_lvl;
    osc     <= {pll_en, hf_en, osc.hf_running, lf_en};
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      test_done();
    end
  end

  csel_ext_osc_model #(.HALF(2)) ext (.i_ref_clk(clk), .i_run(ext_run), .o_clk_lvl(clock_input_pin_lvl));

  csel_clock_select #(.PLL_LOCK_CNT(20), .EXT_STOP_CNT(8)) uut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_osc(osc), .i_sys_clk_lvl(sys_lvl), .i_clock_input_pin_lvl(clock_input_pin_lvl),
    .o_rdata(rdata), .o_sel(sel), .o_hf_osc_en(hf_en), .o_lf_osc_en(lf_en),
    .o_pll_en(pll_en), .o_cpu_run(cpu_run), .o_clock_input_pin_gpio(gpio),
    .o_clock_output_pin_en(clock_output_pin_en), .o_switch_busy(busy));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic reset_with(input csel_cfg_type c);
    @(posedge clk);
    cfg   <= c;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
  endtask : reset_with

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // bounded waits; the limit is the only timing claim made
  task automatic wait_sel(input logic [5:0] exp, input int lim, input string what);
    int n;
    n = 0;
    while (sel !== exp && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({2'h0, sel}, {2'h0, exp}, what);
  endtask : wait_sel

  task automatic wait_run(input logic exp, input string what);
    int n;
    n = 0;
    while (cpu_run !== exp && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, cpu_run}, {7'h0, exp}, what);
  endtask : wait_run

  task automatic t_ext_boot;
    logic [7:0] d;
    reset_with(6'h13);
    chk({2'h0, sel}, {2'h0, SRC_EXT, DIV_NONE}, "ext boot");
    chk({6'h0, gpio, clock_output_pin_en}, 8'h01, "pin roles");
    chk({7'h0, cpu_run}, 8'h01, "no start delay");
    rd_reg(OFF_CONTROL, d);
    chk(d, 8'h38, "control reset");
    wr_reg(OFF_CONTROL, 8'h48);
    ext_run <= 1'b0;
    wait_run(1'b0, "halt on stop");
    rd_reg(OFF_ACTIVE, d);
    chk(d & 8'h40, 8'h40, "halted flag");
    ext_run <= 1'b1;
    wait_run(1'b1, "resume");
    rd_reg(OFF_CONTROL, d);
    chk(d, 8'h48, "state kept");
  endtask : t_ext_boot

  task automatic t_runtime_switch;
    logic [7:0] d;
    wr_reg(OFF_CONTROL, 8'h7a);
    wait_sel({SRC_HF, 4'h0}, 200, "to hf");
    rd_reg(OFF_STATUS, d);
    chk(d, 8'h11, "hf ready stable");
    wr_reg(OFF_CONTROL, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, busy}, 8'h01, "switch busy");
    wait_sel({SRC_LF, DIV_NONE}, 2000, "to lf");
    chk({7'h0, hf_en}, 8'h00, "hf off on lf");
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h02, 8'h02, "lf ready");
    wr_reg(OFF_CONTROL, 8'h01);
    wait_sel({SRC_EXT, DIV_NONE}, 200, "reserved acts cleared");
  endtask : t_runtime_switch

  task automatic t_pll;
    logic [7:0] d;
    reset_with(6'h30);
    chk({2'h0, sel}, {2'h0, SRC_HF, 4'h5}, "internal boot");
    chk({6'h0, gpio, clock_output_pin_en}, 8'h02, "pin roles int");
    wr_reg(OFF_CONTROL, 8'hf0);
    wait_sel({SRC_PLL, DIV_PLL_BASE}, 300, "to pll");
    rd_reg(OFF_STATUS, d);
    chk(d, 8'h51, "pll ready");
    wr_reg(OFF_CONTROL, 8'hf2);
    wait_sel({SRC_HF, 4'h1}, 200, "no pll on select");
    chk({7'h0, pll_en}, 8'h00, "pll off on select");
    wr_reg(OFF_CONTROL, 8'h92);
    wait_sel({SRC_HF, 4'h9}, 20, "lowest hf code");
    wr_reg(OFF_CONTROL, 8'hfa);
    wait_sel({SRC_HF, 4'h0}, 20, "same source fast");
    wr_reg(OFF_STATUS, 8'hff);
    rd_reg(OFF_CONTROL, d);
    chk(d, 8'hfa, "status write ignored");
    rd_reg(2'h3, d);
    chk(d, 8'h00, "unmapped read");
  endtask : t_pll

  task automatic t_timers;
    reset_with(6'h21);
    @(posedge clk);
    #1;
    chk({7'h0, lf_en}, 8'h01, "lf for timers");
    reset_with(6'h1a);
    chk({7'h0, lf_en}, 8'h01, "lf for watchdog");
    chk({2'h0, sel}, {2'h0, SRC_EXT, DIV_NONE}, "ext medium boot");
  endtask : t_timers

  task automatic test_done;
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial
  begin
    t_ext_boot();
    t_runtime_switch();
    t_pll();
    t_timers();
    test_done();
  end
endmodule : tb
